/* core/rsr_pkg.sv */
/*
  Shared constants of the radio status register bank: register
  addresses, header and field bit positions, radio state codes and the
  serial port states.
  Assumes nothing of its surroundings.
*/
package rsr_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_PKT = 6'h38;
  localparam logic [5:0] ADDR_DAC = 6'h39;
  localparam logic [5:0] ADDR_TXL = 6'h3A;
  localparam logic [5:0] ADDR_RXL = 6'h3B;
  localparam logic [5:0] ADDR_RC1 = 6'h3C;
  localparam logic [5:0] ADDR_RC0 = 6'h3D;
  localparam int HDR_RW    = 7;
  localparam int HDR_BURST = 6;
  localparam int B_CRC     = 7;
  localparam int B_CS      = 6;
  localparam int B_PQH     = 5;
  localparam int B_CCA     = 4;
  localparam int B_SFD     = 3;
  localparam int B_GO2     = 2;
  localparam int B_GO0     = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] ST_IDLE   = 5'h01;
  localparam logic [4:0] ST_RX     = 5'h0D;
  localparam logic [4:0] ST_RX_END = 5'h0E;
  localparam logic [4:0] ST_RX_RST = 5'h0F;
  localparam logic [4:0] ST_RX_OVF = 5'h11;
  localparam logic [4:0] ST_TX     = 5'h13;
  localparam logic [4:0] ST_TX_END = 5'h14;
  localparam logic [2:0] PIN_INIT  = 3'h2;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_HDR  = 2'b01,
    SPI_DATA = 2'b11
  } rsr_spi_t;

  function automatic logic in_rx(input logic [4:0] s);
    return (s == ST_RX) || (s == ST_RX_END) || (s == ST_RX_RST);
  endfunction

  function automatic logic in_tx(input logic [4:0] s);
    return (s == ST_TX) || (s == ST_TX_END);
  endfunction
endpackage

/* core/rsr_sync.sv */
/*
  Two-stage synchroniser for a group of asynchronous pin inputs.
  Assumes each bit changes slowly against clk_sys_i.
*/
`timescale 1ns/1ns
module rsr_sync #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsr_sync_t;

  rsr_sync_t r;
  rsr_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= {INIT, INIT};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign q_o = r.s2;
endmodule

/* core/rsr_pkt_flags.sv */
/*
  Packet status flags: CRC result, carrier sense, preamble quality hit,
  channel clear and frame delimiter.
  Assumes all inputs come from radio logic on clk_sys_i; event inputs
  are one-cycle pulses.
*/
`timescale 1ns/1ns
module rsr_pkt_flags #(
  parameter int PQ_W = 8
) (
  input  wire logic            clk_sys_i,
  input  wire logic            resetn_i,
  input  wire logic            ce_i,
  input  wire logic [4:0]      radio_fsm_state_i,
  input  wire logic            crc_done_i,
  input  wire logic            crc_pass_i,
  input  wire logic            carrier_sense_i,
  input  wire logic [PQ_W-1:0] preamble_quality_indicator_i,
  input  wire logic [PQ_W-1:0] preamble_quality_threshold_i,
  input  wire logic            channel_free_i,
  input  wire logic            sync_found_i,
  input  wire logic            packet_end_i,
  input  wire logic            packet_drop_i,
  output logic                 crc_ok_o,
  output logic                 carrier_sense_o,
  output logic                 preamble_quality_hit_o,
  output logic                 channel_clear_flag_o,
  output logic                 frame_delimiter_flag_o
);
  if (PQ_W < 1) begin : g_bad_pq_w
    $error("PQ_W must be at least 1");
  end

  typedef struct packed {
    logic       crc;
    logic       cs;
    logic       pqh;
    logic       cca;
    logic       frame_delimiter_flag;
    logic [4:0] prev;
  } rsr_flag_t;

  rsr_flag_t r;
  rsr_flag_t next_r;
  logic      st_rx;
  logic      entering;
  logic      pq_low;

  assign st_rx    = rsr_pkg::in_rx(radio_fsm_state_i);
  assign entering = (radio_fsm_state_i == rsr_pkg::ST_RX)
                    && !rsr_pkg::in_rx(r.prev);
  assign pq_low   = preamble_quality_indicator_i
                    < preamble_quality_threshold_i;

  always_comb begin
    next_r      = r;
    next_r.prev = radio_fsm_state_i;
    if (entering || radio_fsm_state_i == rsr_pkg::ST_RX_RST) begin
      next_r.crc = 1'b0;
    end
    // A check result in the clearing cycle still lands
    if (crc_done_i) begin
      next_r.crc = crc_pass_i;
    end
    next_r.cs = (radio_fsm_state_i == rsr_pkg::ST_IDLE) ? 1'b0
                : carrier_sense_i;
    // Outside RX the flag is frozen until RX is entered again
    if (entering) begin
      next_r.pqh = 1'b0;
    end else if (st_rx) begin
      next_r.pqh = !pq_low;
    end
    next_r.cca = channel_free_i;
    if (rsr_pkg::in_tx(radio_fsm_state_i)
        || radio_fsm_state_i == rsr_pkg::ST_RX_OVF) begin
      next_r.frame_delimiter_flag = 1'b0;
    end else begin
      if (packet_end_i || packet_drop_i) begin
        next_r.frame_delimiter_flag = 1'b0;
      end
      if (sync_found_i && st_rx) begin
        next_r.frame_delimiter_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign crc_ok_o               = r.crc;
  assign carrier_sense_o        = r.cs;
  assign preamble_quality_hit_o = r.pqh;
  assign channel_clear_flag_o   = r.cca;
  assign frame_delimiter_flag_o = r.frame_delimiter_flag;

  default clocking fcb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // The flag counts as it stands in the first cycle outside RX
  sequence s_rx_exit;
    (ce_i && st_rx) ##1 (ce_i && !st_rx && r.pqh);
  endsequence

  a_crc_result : assert property (
    ce_i && crc_done_i |=> crc_ok_o == $past(crc_pass_i))
    else $error("crc flag does not follow the check result");
  a_crc_restart : assert property (
    ce_i && !crc_done_i && radio_fsm_state_i == rsr_pkg::ST_RX_RST
    |=> !crc_ok_o)
    else $error("crc flag survives an RX restart");
  a_cs_idle_clear : assert property (
    ce_i && radio_fsm_state_i == rsr_pkg::ST_IDLE |=> !carrier_sense_o)
    else $error("carrier sense set in idle");
  a_pq_hold_out : assert property (
    s_rx_exit |=> preamble_quality_hit_o)
    else $error("preamble hit lost after leaving RX");
  a_pq_below_clear : assert property (
    ce_i && st_rx && pq_low |=> !preamble_quality_hit_o)
    else $error("preamble hit kept below threshold");
  a_sfd_on_sync : assert property (
    ce_i && sync_found_i && st_rx |=> frame_delimiter_flag_o)
    else $error("frame delimiter not set on sync");
  a_sfd_early_drop : assert property (
    ce_i && (radio_fsm_state_i == rsr_pkg::ST_RX_OVF
    || (packet_drop_i && !sync_found_i)) |=> !frame_delimiter_flag_o)
    else $error("frame delimiter kept after drop or overrun");
endmodule

/* core/rsr_top.sv */
/*
  Read-only status register bank of the packet transceiver, reached
  over the serial register port (chip select, clock, data in/out).
  Assumes: status inputs come from radio logic on clk_sys_i; the
  serial port pins are asynchronous and at most clk_sys_i / 8.
*/
`timescale 1ns/1ns
module rsr_top #(
  parameter int PQ_W = 8
) (
  input  wire logic            clk_sys_i,
  input  wire logic            resetn_i,
  input  wire logic            ce_i,
  input  wire logic            spi_sclk_i,
  input  wire logic            spi_csn_i,
  input  wire logic            spi_si_i,
  output logic                 spi_so_o,
  output logic                 spi_so_oe_o,
  input  wire logic [4:0]      radio_fsm_state_i,
  input  wire logic            crc_done_i,
  input  wire logic            crc_pass_i,
  input  wire logic            carrier_sense_i,
  input  wire logic [PQ_W-1:0] preamble_quality_indicator_i,
  input  wire logic [PQ_W-1:0] preamble_quality_threshold_i,
  input  wire logic            channel_free_i,
  input  wire logic            sync_found_i,
  input  wire logic            packet_end_i,
  input  wire logic            packet_drop_i,
  input  wire logic            general_output_2_i,
  input  wire logic            general_output_0_i,
  input  wire logic            out2_invert_i,
  input  wire logic            out0_invert_i,
  input  wire logic [6:0]      tx_queue_count_i,
  input  wire logic [6:0]      rx_queue_count_i,
  input  wire logic            tx_queue_underrun_i,
  input  wire logic            rx_queue_overrun_i,
  input  wire logic            tx_flush_i,
  input  wire logic            rx_flush_i,
  input  wire logic [7:0]      synth_cal_dac_value_i,
  input  wire logic            rc_cal_done_i,
  input  wire logic [6:0]      rc_cal_one_i,
  input  wire logic [6:0]      rc_cal_zero_i
);
  if (PQ_W < 1 || PQ_W > 8) begin : g_bad_pq_w
    $error("PQ_W must lie in 1..8");
  end

  typedef struct packed {
    rsr_pkg::rsr_spi_t spi;
    logic              sclk_q;
    logic [2:0]        bits;
    logic [7:0]        sin;
    logic [7:0]        sout;
    logic [5:0]        addr;
    logic              rd_ok;
    logic              so;
    logic              go2;
    logic              go0;
    logic [6:0]        txc;
    logic [6:0]        rxc;
    logic              unr;
    logic              ovr;
    logic [7:0]        dac;
    logic [6:0]        rc1;
    logic [6:0]        rc0;
  } rsr_top_state_t;

  rsr_top_state_t r;
  rsr_top_state_t next_r;

  logic       sclk_s;
  logic       csn_s;
  logic       si_s;
  logic       rise;
  logic       fall;
  logic       crc_ok;
  logic       cs_flag;
  logic       pq_hit;
  logic       cc_flag;
  logic       sfd_flag;
  logic       tx_now;
  logic [7:0] pkt;
  logic [7:0] hdr_byte;
  logic [7:0] hdr_val;
  logic       hdr_rd;

  function automatic logic [7:0] reg_value(
    input logic [5:0]     a,
    input rsr_top_state_t s,
    input logic [7:0]     p
  );
    logic [7:0] v;
    v = '0;
    case (a)
      rsr_pkg::ADDR_PKT: v = p;
      rsr_pkg::ADDR_DAC: v = s.dac;
      rsr_pkg::ADDR_TXL: v = {s.unr, s.txc};
      rsr_pkg::ADDR_RXL: v = {s.ovr, s.rxc};
      rsr_pkg::ADDR_RC1: v = {1'b0, s.rc1};
      rsr_pkg::ADDR_RC0: v = {1'b0, s.rc0};
      default:           v = '0;
    endcase
    return v;
  endfunction

  // Pins are asynchronous; chip select idles high out of reset
  rsr_sync #(
    .W    (3),
    .INIT (rsr_pkg::PIN_INIT)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .d_i       ({spi_sclk_i, spi_csn_i, spi_si_i}),
    .q_o       ({sclk_s, csn_s, si_s})
  );

  rsr_pkt_flags #(
    .PQ_W (PQ_W)
  ) u_flags (
    .clk_sys_i                    (clk_sys_i),
    .resetn_i                     (resetn_i),
    .ce_i                         (ce_i),
    .radio_fsm_state_i            (radio_fsm_state_i),
    .crc_done_i                   (crc_done_i),
    .crc_pass_i                   (crc_pass_i),
    .carrier_sense_i              (carrier_sense_i),
    .preamble_quality_indicator_i (preamble_quality_indicator_i),
    .preamble_quality_threshold_i (preamble_quality_threshold_i),
    .channel_free_i               (channel_free_i),
    .sync_found_i                 (sync_found_i),
    .packet_end_i                 (packet_end_i),
    .packet_drop_i                (packet_drop_i),
    .crc_ok_o                     (crc_ok),
    .carrier_sense_o              (cs_flag),
    .preamble_quality_hit_o       (pq_hit),
    .channel_clear_flag_o         (cc_flag),
    .frame_delimiter_flag_o       (sfd_flag)
  );

  assign rise     = sclk_s && !r.sclk_q;
  assign fall     = !sclk_s && r.sclk_q;
  assign tx_now   = rsr_pkg::in_tx(radio_fsm_state_i);
  assign hdr_byte = {r.sin[6:0], si_s};

  always_comb begin
    pkt                 = '0;
    pkt[rsr_pkg::B_CRC] = crc_ok;
    pkt[rsr_pkg::B_CS]  = cs_flag;
    pkt[rsr_pkg::B_PQH] = pq_hit;
    pkt[rsr_pkg::B_CCA] = cc_flag;
    pkt[rsr_pkg::B_SFD] = sfd_flag && !tx_now;
    pkt[rsr_pkg::B_GO2] = r.go2;
    pkt[rsr_pkg::B_GO0] = r.go0;
  end

  // Only burst reads of the status window are answered
  assign hdr_rd  = hdr_byte[rsr_pkg::HDR_RW]
                   && hdr_byte[rsr_pkg::HDR_BURST]
                   && hdr_byte[rsr_pkg::ADDR_W-1:0] >= rsr_pkg::ADDR_PKT
                   && hdr_byte[rsr_pkg::ADDR_W-1:0] <= rsr_pkg::ADDR_RC0;
  assign hdr_val = reg_value(hdr_byte[rsr_pkg::ADDR_W-1:0], r, pkt);

  always_comb begin
    next_r        = r;
    next_r.sclk_q = sclk_s;
    // Pads carry the inverted level; undo it for the readback
    next_r.go2    = general_output_2_i ^ out2_invert_i;
    next_r.go0    = general_output_0_i ^ out0_invert_i;
    next_r.txc    = tx_queue_count_i;
    next_r.rxc    = rx_queue_count_i;
    next_r.dac    = synth_cal_dac_value_i;
    if (rc_cal_done_i) begin
      next_r.rc1 = rc_cal_one_i;
      next_r.rc0 = rc_cal_zero_i;
    end
    // Event wins over a flush in the same cycle
    if (tx_flush_i) begin
      next_r.unr = 1'b0;
    end
    if (tx_queue_underrun_i) begin
      next_r.unr = 1'b1;
    end
    if (rx_flush_i) begin
      next_r.ovr = 1'b0;
    end
    if (rx_queue_overrun_i) begin
      next_r.ovr = 1'b1;
    end
    if (csn_s) begin
      next_r.spi  = rsr_pkg::SPI_IDLE;
      next_r.bits = '0;
      next_r.sout = '0;
      next_r.so   = 1'b0;
    end else begin
      unique case (r.spi)
        rsr_pkg::SPI_IDLE: begin
          next_r.spi = rsr_pkg::SPI_HDR;
        end
        rsr_pkg::SPI_HDR, rsr_pkg::SPI_DATA: begin
          if (rise) begin
            next_r.sin  = hdr_byte;
            next_r.bits = r.bits + 3'h1;
            if (r.bits == rsr_pkg::LAST_BIT) begin
              if (r.spi == rsr_pkg::SPI_HDR) begin
                next_r.spi   = rsr_pkg::SPI_DATA;
                next_r.addr  = hdr_byte[rsr_pkg::ADDR_W-1:0];
                next_r.rd_ok = hdr_rd;
                next_r.sout  = hdr_rd ? hdr_val : '0;
              end else begin
                // Further bytes resample the same register
                next_r.sout = r.rd_ok ? reg_value(r.addr, r, pkt) : '0;
              end
            end
          end
          if (fall) begin
            next_r.so   = r.sout[7];
            next_r.sout = {r.sout[6:0], 1'b0};
          end
        end
        default: begin
          next_r.spi = rsr_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign spi_so_o    = r.so;
  assign spi_so_oe_o = (r.spi != rsr_pkg::SPI_IDLE);

  default clocking tcb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_hdr_last;
    ce_i && !csn_s && r.spi == rsr_pkg::SPI_HDR && rise
    && r.bits == rsr_pkg::LAST_BIT;
  endsequence

  sequence s_data_fall;
    ce_i && !csn_s && r.spi == rsr_pkg::SPI_DATA && fall;
  endsequence

  // End of a data byte: a burst takes the register again
  sequence s_data_last;
    ce_i && !csn_s && r.spi == rsr_pkg::SPI_DATA && rise
    && r.bits == rsr_pkg::LAST_BIT;
  endsequence

  a_hdr_load : assert property (
    s_hdr_last ##0 hdr_rd |=> r.sout == $past(hdr_val))
    else $error("status byte not loaded after read header");
  a_hdr_other : assert property (
    s_hdr_last ##0 !hdr_rd |=> r.sout == '0)
    else $error("non-status header answered with data");
  a_data_shift : assert property (
    s_data_fall |=> spi_so_o == $past(r.sout[7]))
    else $error("data bit not driven after a clock fall");
  a_tx_sfd_zero : assert property (
    tx_now |-> !pkt[rsr_pkg::B_SFD])
    else $error("frame delimiter reads set during transmit");
  a_out2_plain : assert property (
    ce_i |=> pkt[rsr_pkg::B_GO2]
    == ($past(general_output_2_i) ^ $past(out2_invert_i)))
    else $error("output 2 readback keeps inversion");
  a_out0_plain : assert property (
    ce_i |=> pkt[rsr_pkg::B_GO0]
    == ($past(general_output_0_i) ^ $past(out0_invert_i)))
    else $error("output 0 readback keeps inversion");
  a_txcnt_map : assert property (
    ce_i |=> r.txc == $past(tx_queue_count_i))
    else $error("transmit count not tracked");
  a_rxcnt_map : assert property (
    ce_i |=> r.rxc == $past(rx_queue_count_i))
    else $error("receive count not tracked");
  a_dac_map : assert property (
    ce_i |=> reg_value(rsr_pkg::ADDR_DAC, r, pkt)
    == $past(synth_cal_dac_value_i))
    else $error("calibration DAC readback wrong");
  a_rc_latch : assert property (
    ce_i && rc_cal_done_i |=> reg_value(rsr_pkg::ADDR_RC1, r, pkt)
    == {1'b0, $past(rc_cal_one_i)} ##0 r.rc0 == $past(rc_cal_zero_i))
    else $error("RC calibration result not latched");
  a_unr_sticky : assert property (
    ce_i && (tx_queue_underrun_i || (r.unr && !tx_flush_i)) |=> r.unr)
    else $error("transmit underrun flag lost");
  a_ovr_sticky : assert property (
    ce_i && (rx_queue_overrun_i || (r.ovr && !rx_flush_i)) |=> r.ovr)
    else $error("receive overrun flag lost");
  a_cca_map : assert property (
    ce_i |=> pkt[rsr_pkg::B_CCA] == $past(channel_free_i))
    else $error("channel clear flag does not follow assessment");

  // Port side: nothing driven while deselected, zeros during header
  a_oe_idle : assert property (
    ce_i && csn_s |=> !spi_so_oe_o && !spi_so_o)
    else $error("data out still driven while deselected");
  a_hdr_zero : assert property (
    ce_i && !csn_s && r.spi == rsr_pkg::SPI_HDR && fall |=> !spi_so_o)
    else $error("data out not zero during header");
  a_burst_dac : assert property (
    s_data_last ##0 (r.rd_ok && r.addr == rsr_pkg::ADDR_DAC)
    |=> r.sout == $past(r.dac))
    else $error("burst byte does not resample the register");
  a_burst_refused : assert property (
    s_data_last ##0 !r.rd_ok |=> r.sout == '0)
    else $error("refused header answered in a later byte");
  a_rc_hold : assert property (
    ce_i && !rc_cal_done_i |=> $stable(r.rc1) && $stable(r.rc0))
    else $error("RC calibration result changed without a run");
  a_unr_flush : assert property (
    ce_i && tx_flush_i && !tx_queue_underrun_i |=> !r.unr)
    else $error("transmit underrun flag survives a flush");
  a_ovr_flush : assert property (
    ce_i && rx_flush_i && !rx_queue_overrun_i |=> !r.ovr)
    else $error("receive overrun flag survives a flush");
endmodule

/* verification/rsr_host_model.sv */
/*
  Behavioural host microcontroller on the serial register port:
  mode 0, MSB first, 160 ns serial clock, one header and one data byte per frame.
  Assumes the device drives so at most four system clocks after a fall.
*/
`timescale 1ns/1ns
module rsr_host_model (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    si_o   = 1'b0;
  end

  // Lock is never judged from status bits 2 and 0
  task automatic xfer(input logic [7:0] hdr, output logic [7:0] d);
    csn_o = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      si_o = hdr[i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    // Data in is ignored by the device, so keep it moving
    for (int i = 7; i >= 0; i--) begin
      si_o = ~si_o;
      #80 sclk_o = 1'b1;
      #10 d[i] = so_i;
      #70 sclk_o = 1'b0;
    end
    #80 csn_o = 1'b1;
    si_o = ~si_o;
    #200;
  endtask
endmodule

/* verification/tb.sv */
/*
  Self-checking bench of the status register bank: random radio
  activity, a reference model of every field, reads over the port.
  Assumes rsr_host_model as the serial host.
*/
`timescale 1ns/1ns
module tb;
  logic        clk, rstn, ce, sclk, csn, si, so, so_oe;
  int          oe_miss = 0;
  logic [4:0]  st;
  logic        crc_d, crc_p, cs, cf, sync, pend, pdrop;
  logic        go2, go0, inv2, inv0, und, ovf, txf, rxf, rcd;
  logic [7:0]  preamble_quality_indicator, preamble_quality_threshold, dac;
  logic [6:0]  txc, rxc, rc1, rc0;
  logic [31:0] rnd = 32'h0000_c0f9;
  int          error_cnt = 0;
  int          total_checks = 0;
  bit          m_crc, m_cs, m_pq, m_cca, m_sfd, m_und, m_ovf;
  logic [6:0]  m_rc1, m_rc0;
  int          pst;
  logic [7:0]  got [0:8];
  logic [4:0]  st_tab [0:7] = '{5'h01, 5'h0D, 5'h0E, 5'h0F,
                                 5'h11, 5'h13, 5'h14, 5'h08};
  logic [7:0]  hdr_tab [0:8] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC,
                                  8'hFD, 8'hF7, 8'hB8, 8'h78};

  rsr_top dut_u (
    .clk_sys_i(clk), .resetn_i(rstn), .ce_i(ce),
    .spi_sclk_i(sclk), .spi_csn_i(csn), .spi_si_i(si),
    .spi_so_o(so), .spi_so_oe_o(so_oe), .radio_fsm_state_i(st),
    .crc_done_i(crc_d), .crc_pass_i(crc_p), .carrier_sense_i(cs),
    .preamble_quality_indicator_i(preamble_quality_indicator),
    .preamble_quality_threshold_i(preamble_quality_threshold), .channel_free_i(cf),
    .sync_found_i(sync), .packet_end_i(pend), .packet_drop_i(pdrop),
    .general_output_2_i(go2), .general_output_0_i(go0),
    .out2_invert_i(inv2), .out0_invert_i(inv0),
    .tx_queue_count_i(txc), .rx_queue_count_i(rxc),
    .tx_queue_underrun_i(und), .rx_queue_overrun_i(ovf),
    .tx_flush_i(txf), .rx_flush_i(rxf), .synth_cal_dac_value_i(dac),
    .rc_cal_done_i(rcd), .rc_cal_one_i(rc1), .rc_cal_zero_i(rc0)
  );

  rsr_host_model host_u (.sclk_o(sclk), .csn_o(csn), .si_o(si),
                         .so_i(so));

  // Output enable must stand through every clock pulse of a frame
  always @(negedge clk) begin
    if (sclk && !csn && !so_oe) oe_miss++;
  end

  function automatic bit is_rx(input int s);
    return s >= 13 && s <= 15;
  endfunction

  function automatic bit is_tx(input int s);
    return s == 19 || s == 20;
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++) begin
      x = {x[30:0], ^(x & 32'h8020_0003)};
    end
    return x;
  endfunction

  // Reference model, one step per system clock with ce set
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {m_crc, m_cs, m_pq, m_cca, m_sfd, m_und, m_ovf} = '0;
      {m_rc1, m_rc0} = '0;
      pst = 0;
    end else if (ce) begin
      if (crc_d) m_crc = crc_p;
      else if ((st == 13 && !is_rx(pst)) || st == 15) m_crc = 0;
      m_cs = (st == 1) ? 1'b0 : cs;
      if (is_rx(st)) m_pq = (st == 13 && !is_rx(pst)) ? 1'b0 : preamble_quality_indicator >= preamble_quality_threshold;
      if (is_tx(st) || st == 17) m_sfd = 0;
      else if (sync && is_rx(st)) m_sfd = 1;
      else if (pend || pdrop) m_sfd = 0;
      m_cca = cf;
      if (und) m_und = 1;
      else if (txf) m_und = 0;
      if (ovf) m_ovf = 1;
      else if (rxf) m_ovf = 0;
      if (rcd) {m_rc1, m_rc0} = {rc1, rc0};
      pst = st;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One cycle of random radio activity
  task automatic stir();
    logic [31:0] a;
    logic [31:0] b;
    @(posedge clk);
    #2;
    rnd = lfsr(rnd);
    a = rnd;
    rnd = lfsr(rnd);
    b = rnd;
    st = st_tab[a[2:0]];
    ce = a[20] | b[3];
    {crc_d, crc_p, cs, cf, sync, pend, pdrop, go2, go0, inv2} = a[12:3];
    {inv0, und, ovf, txf, rxf, rcd} = a[18:13];
    {preamble_quality_indicator, dac} = {a[26:19], b[7:0]};
    {preamble_quality_threshold, txc, rxc} = {b[15:8], b[22:16], b[29:23]};
    {rc1, rc0} = {a[31:25], b[31:30], a[31:27]};
  endtask

  task automatic check_all();
    logic [7:0] e;
    // Keep every pin change off the sampling edge
    #2;
    for (int i = 0; i < 9; i++) begin
      host_u.xfer(hdr_tab[i], got[i]);
    end
    e = {m_crc, m_cs, m_pq, m_cca, m_sfd & !is_tx(st), go2 ^ inv2, 1'b0,
         go0 ^ inv0};
    chk(got[0] & 8'hF0, e & 8'hF0);
    chk(got[0] & 8'h0F, e & 8'h0F);
    chk(got[1], dac);
    chk(got[2], {m_und, txc});
    chk(got[3], {m_ovf, rxc});
    chk(got[4], {1'b0, m_rc1});
    chk(got[5], {1'b0, m_rc0});
    for (int i = 6; i < 9; i++) begin
      chk(got[i], 8'h00);
    end
    chk({7'h00, so_oe}, 8'h00);
    chk((oe_miss > 0) ? 8'h01 : 8'h00, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    st = 5'h01;
    {crc_d, crc_p, cs, cf, sync, pend, pdrop, go2, go0, inv2} = '0;
    {inv0, und, ovf, txf, rxf, rcd} = '0;
    {preamble_quality_indicator, preamble_quality_threshold, dac, txc, rxc, rc1, rc0} = '0;
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (5) @(posedge clk);
    for (int r = 0; r < 30; r++) begin
      if (r == 15) begin
        // Mid-run reset: sticky flags and RC results restart at zero
        @(posedge clk);
        #2 rstn = 1'b0;
        repeat (3) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (3) @(posedge clk);
      end
      repeat (4) stir();
      @(posedge clk);
      #2;
      // Inputs frozen so the snapshot cannot race the model
      {crc_d, sync, pend, pdrop, und, ovf, txf, rxf, rcd} = '0;
      ce = 1'b1;
      repeat (3) @(posedge clk);
      check_all();
    end
    report_and_stop();
  end

  initial begin
    #1_500_000;
    error_cnt++;
    report_and_stop();
  end
endmodule
